/* pll_ctrl_pkg.sv */
// Constants, register map and reset values for the loop programming block.
// Assumes a byte-wide register file reached over a 32-bit Avalon-MM slave.
// How it works
// - With auto bandwidth on, tracking select is read-only and shows loop mode.
// - With auto off, software writes tracking select and it forces the mode.
// - Last manual tracking value is kept hidden during auto and restored after.
// - Reset clears tracking select; one means tracking, zero acquisition.
// - Multiplier is 12 bits; high register low nibble is top; upper nibble reads zero.
// - A multiplier of zero divides exactly as a multiplier of one.
// - Multiplier writes are ignored while the loop power bit is set.
// - Eight-bit range register gives L; writes ignored while the loop is on.
// - Four-bit reference divider, locked while on, zero acts as one, top reads zero.
// - In auto mode each lock change sets the flag; interrupt only when enabled.
// - In manual mode interrupts are blocked and the flag reads zero.
// - Base select may pick the VCO clock even while unlocked.
// - Wait leaves the clock generator untouched.
// - Stop without oscillator option disables oscillator and loop, outputs low.
// - Stop with VCO as base source clears base select, which stays clear.
// - Stop with oscillator option set shuts the loop but keeps the oscillator.
// - In break with clear enable zero, accesses leave the flag; with one, reads clear it.
// - Otherwise any read of the control register clears the lock-change flag.
package pll_ctrl_pkg;
   localparam int ADDR_W = 3;
   // Word indexes on the bus; byte address is four times the index.
   localparam logic [ADDR_W-1:0] CTRL_IDX = 3'h0;
   localparam logic [ADDR_W-1:0] BW_IDX = 3'h1;
   localparam logic [ADDR_W-1:0] MULH_IDX = 3'h2;
   localparam logic [ADDR_W-1:0] MULL_IDX = 3'h3;
   localparam logic [ADDR_W-1:0] VRS_IDX = 3'h4;
   localparam logic [ADDR_W-1:0] RDS_IDX = 3'h5;
   // Control register fields.
   localparam int CTRL_IE_BIT = 7;
   localparam int CTRL_FLAG_BIT = 6;
   localparam int CTRL_ON_BIT = 5;
   localparam int CTRL_BCS_BIT = 4;
   localparam int CTRL_PRE_LSB = 2;
   localparam int CTRL_VPR_LSB = 0;
   // Bandwidth register fields.
   localparam int BW_AUTO_BIT = 7;
   localparam int BW_LOCK_BIT = 6;
   localparam int BW_TRK_BIT = 5;
   // Reset values.
   localparam logic [3:0] MULH_RST = 4'h0;
   localparam logic [7:0] MULL_RST = 8'h40;
   localparam logic [7:0] VRS_RST = 8'h40;
   localparam logic [3:0] RDS_RST = 4'h1;
   localparam logic [1:0] PRE_RST = 2'h0;
   localparam logic [1:0] VPR_RST = 2'h0;
endpackage

/* pll_ctrl.sv */
// Loop programming and lock control: register file, write protection, lock flag
// and stop/wait handling. Assumes the analog loop reports lock and acquisition
// state on plain inputs, and low-power and break states come from system logic.
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl
   import pll_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic lockDetect,
   input wire logic loopTracking,
   input wire logic stopMode,
   input wire logic oscillatorRunsInStop,
   input wire logic breakActive,
   input wire logic breakClearEnable,
   output logic loopEnable,
   output logic oscillatorEnable,
   output logic trackingForce,
   output logic autoBandwidth,
   output logic baseClockSourceSelect,
   output logic [11:0] feedbackMultiplier,
   output logic [7:0] vcoRangeMultiplier,
   output logic [3:0] referenceDivisionFactor,
   output logic [1:0] prescaleSelect,
   output logic [1:0] vcoPowerRange,
   output logic loopInterrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops.
   logic rstMeta_r;
   logic rstSync_r;

   // Asynchronous assert, synchronous release.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle on every access so read data comes from a flop.
   // Trading one cycle per access for a registered read path keeps the read
   // multiplexer out of the bus timing. The flag clear rides on the first edge
   // of a read, so each read clears the flag exactly once.
   logic ack_r;
   logic busReq;
   logic wrAcc;
   logic rdAcc;
   logic mapped;

   assign busReq = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~ack_r;
   assign wrAcc = avs_write & ack_r & avs_byteenable[0];
   assign rdAcc = avs_read & ~ack_r;
   assign mapped = (avs_address <= RDS_IDX);

   // Acknowledge toggles so back-to-back requests each see one wait state.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= busReq & ~ack_r;
      end
   end

   // Registered response; an unmapped address answers decode error.
   // It loads on the same edge as the read data, so both stand together until
   // the next access begins.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         avs_response <= 2'h0;
      end else if (busReq & ~ack_r) begin
         avs_response <= mapped ? 2'h0 : 2'h3;
      end
   end

   // A write commits on the edge where waitrequest is low, which is the edge on
   // which ack_r is high; byte lane zero must be enabled for it to land.
   function automatic logic wrTo(input logic [ADDR_W-1:0] idx);
      return wrAcc && (avs_address == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control register.
   // Loop power and base select guard each other: the loop cannot be turned off
   // while it drives the base clock, and the base clock cannot move to the VCO
   // while the loop is off or the range is zero. Moving to the VCO from an off
   // loop therefore needs one write to power up and a second to switch.
   logic ie_r;
   logic on_r;
   logic bcs_r;
   logic [1:0] pre_r;
   logic [1:0] vpr_r;
   logic auto_r;
   logic [7:0] vrs_r;
   logic vrsZero;
   logic [7:0] wd;

   assign wd = avs_writedata[7:0];
   assign vrsZero = (vrs_r == 8'h00);

   // Interrupt enable only writable in auto mode and reads zero otherwise.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         ie_r <= 1'b0;
      end else if (!auto_r) begin
         ie_r <= 1'b0;
      end else if (wrTo(CTRL_IDX)) begin
         ie_r <= wd[CTRL_IE_BIT];
      end
   end

   // Loop power: cannot clear while the VCO drives the base clock; a zero range
   // or stop forces it off. Wait has no input here, so it changes nothing.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         on_r <= 1'b1;
      end else if (stopMode || vrsZero) begin
         on_r <= 1'b0;
      end else if (wrTo(CTRL_IDX)) begin
         on_r <= wd[CTRL_ON_BIT] | bcs_r;
      end
   end

   // Base select: set only with the loop on and range nonzero; lock is not
   // checked, so software carries that burden. Stop clears it and it stays clear.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         bcs_r <= 1'b0;
      end else if (stopMode) begin
         bcs_r <= 1'b0;
      end else if (vrsZero || !on_r) begin
         bcs_r <= 1'b0;
      end else if (wrTo(CTRL_IDX)) begin
         bcs_r <= wd[CTRL_BCS_BIT];
      end
   end

   // Prescaler and power-of-two range, frozen while the loop is on.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         pre_r <= PRE_RST;
         vpr_r <= VPR_RST;
      end else if (wrTo(CTRL_IDX) && !on_r) begin
         pre_r <= wd[CTRL_PRE_LSB +: 2];
         vpr_r <= wd[CTRL_VPR_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock-change flag.
   // The edge detector starts from the unlocked level, which is also what the
   // loop reports out of reset, so no false change is seen after reset.
   // Writes to the control register never clear the flag; reads do when break
   // protection allows it, and leaving auto mode clears it as well.
   logic lockPrev_r;
   logic flag_r;
   logic lockEdge;
   logic flagClear;

   assign lockEdge = auto_r && (lockDetect != lockPrev_r);
   assign flagClear = rdAcc && (avs_address == CTRL_IDX) &&
      (!breakActive || breakClearEnable);

   // Previous lock level for edge detection.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         lockPrev_r <= 1'b0;
      end else begin
         lockPrev_r <= lockDetect;
      end
   end

   // A lock change in the same cycle as a clearing read wins over the clear.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         flag_r <= 1'b0;
      end else if (!auto_r) begin
         flag_r <= 1'b0;
      end else if (lockEdge) begin
         flag_r <= 1'b1;
      end else if (flagClear) begin
         flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bandwidth register and hidden manual tracking value.
   // A write that sets the auto bit from manual mode still stores its tracking
   // bit, because the write is judged against the old mode. Later writes made
   // in auto mode leave the hidden value alone.
   logic trkManual_r;

   // Auto select is always writable.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         auto_r <= 1'b0;
      end else if (wrTo(BW_IDX)) begin
         auto_r <= wd[BW_AUTO_BIT];
      end
   end

   // The manual value is only written in manual mode and survives auto mode.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         trkManual_r <= 1'b0;
      end else if (wrTo(BW_IDX) && !auto_r) begin
         trkManual_r <= wd[BW_TRK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming registers, all frozen while the loop is on.
   // A write that arrives while the loop is on is dropped, not queued; software
   // must turn the loop off, program it, and turn it on again.
   logic [3:0] mulh_r;
   logic [7:0] mull_r;
   logic [3:0] rds_r;

   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         mulh_r <= MULH_RST;
         mull_r <= MULL_RST;
      end else if (!on_r) begin
         if (wrTo(MULH_IDX)) begin
            mulh_r <= wd[3:0];
         end
         if (wrTo(MULL_IDX)) begin
            mull_r <= wd;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         vrs_r <= VRS_RST;
      end else if (wrTo(VRS_IDX) && !on_r) begin
         vrs_r <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         rds_r <= RDS_RST;
      end else if (wrTo(RDS_IDX) && !on_r) begin
         rds_r <= wd[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered during the wait cycle.
   // Unused bits and unmapped indexes read as zero, so a read-modify-write of
   // any register never sets a reserved bit.
   logic [7:0] rdByte;

   always_comb begin
      rdByte = 8'h00;
      unique case (avs_address)
         CTRL_IDX: begin
            rdByte[CTRL_IE_BIT] = ie_r;
            rdByte[CTRL_FLAG_BIT] = flag_r & auto_r;
            rdByte[CTRL_ON_BIT] = on_r;
            rdByte[CTRL_BCS_BIT] = bcs_r;
            rdByte[CTRL_PRE_LSB +: 2] = pre_r;
            rdByte[CTRL_VPR_LSB +: 2] = vpr_r;
         end
         BW_IDX: begin
            rdByte[BW_AUTO_BIT] = auto_r;
            rdByte[BW_LOCK_BIT] = auto_r & lockDetect;
            rdByte[BW_TRK_BIT] = auto_r ? loopTracking : trkManual_r;
         end
         MULH_IDX: rdByte = {4'h0, mulh_r};
         MULL_IDX: rdByte = mull_r;
         VRS_IDX: rdByte = vrs_r;
         RDS_IDX: rdByte = {4'h0, rds_r};
         default: rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rdAcc) begin
         avs_readdata <= {24'h00_0000, rdByte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to the analog loop and clock selector.
   // Zero multiplier and zero divider are presented as one so the divider
   // never sees a modulus of zero.
   // The analog side sees every programming value one cycle after its register,
   // which keeps a single flop boundary between the bus and the loop.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         feedbackMultiplier <= {MULH_RST, MULL_RST};
         referenceDivisionFactor <= RDS_RST;
         vcoRangeMultiplier <= VRS_RST;
         prescaleSelect <= PRE_RST;
         vcoPowerRange <= VPR_RST;
      end else begin
         feedbackMultiplier <= ({mulh_r, mull_r} == 12'h000) ? 12'h001 : {mulh_r, mull_r};
         referenceDivisionFactor <= (rds_r == 4'h0) ? 4'h1 : rds_r;
         vcoRangeMultiplier <= vrs_r;
         prescaleSelect <= pre_r;
         vcoPowerRange <= vpr_r;
      end
   end

   // Stop turns off the loop always and the oscillator unless the option holds it.
   // Wait mode has no input here, so the loop and base select keep running
   // through it unless software has changed them first.
   always_ff @(posedge clk_sys or negedge rstSync_r) begin
      if (!rstSync_r) begin
         loopEnable <= 1'b0;
         oscillatorEnable <= 1'b0;
         baseClockSourceSelect <= 1'b0;
         trackingForce <= 1'b0;
         autoBandwidth <= 1'b0;
         loopInterrupt <= 1'b0;
      end else begin
         loopEnable <= on_r & ~stopMode;
         oscillatorEnable <= ~stopMode | oscillatorRunsInStop;
         baseClockSourceSelect <= bcs_r & ~stopMode;
         trackingForce <= trkManual_r;
         autoBandwidth <= auto_r;
         loopInterrupt <= flag_r & ie_r & auto_r & ~stopMode;
      end
   end

endmodule // pll_ctrl
`default_nettype wire

/* pll_ctrl_checker.sv */
// Checker for the loop programming block: bus timing, write lock, stop and flag behaviour.
// Assumes it is bound to pll_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_checker
   import pll_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic stopMode,
   input wire logic oscillatorRunsInStop,
   input wire logic loopEnable,
   input wire logic oscillatorEnable,
   input wire logic autoBandwidth,
   input wire logic baseClockSourceSelect,
   input wire logic [11:0] feedbackMultiplier,
   input wire logic [7:0] vcoRangeMultiplier,
   input wire logic [3:0] referenceDivisionFactor,
   input wire logic loopInterrupt
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic rdDone;
   // A read completes at the edge where waitrequest is seen low.
   assign rdDone = avs_read && !avs_waitrequest;
   ////////////////////////////////////////////////////////////////////////////////
   a_mul_nonzero:
   assert property (feedbackMultiplier != 12'h000) else $error("multiplier output is zero");
   a_div_nonzero:
   assert property (referenceDivisionFactor != 4'h0) else $error("divider output is zero");
   a_prog_frozen:
   assert property (loopEnable [*3] |-> $stable(feedbackMultiplier) && $stable(vcoRangeMultiplier)
      && $stable(referenceDivisionFactor)) else $error("programming changed while loop on");
   a_stop_dark:
   assert property ((stopMode && !oscillatorRunsInStop) [*3] |-> !oscillatorEnable && !loopEnable
      && !loopInterrupt) else $error("outputs alive in full stop");
   a_stop_base:
   assert property (stopMode [*3] |-> !baseClockSourceSelect) else $error("base select kept in stop");
   a_stop_osc:
   assert property ((stopMode && oscillatorRunsInStop) [*3] |-> oscillatorEnable && !loopEnable)
      else $error("oscillator option ignored in stop");
   a_range_zero:
   assert property (vcoRangeMultiplier == 8'h00 |-> ##[0:2] (!loopEnable && !baseClockSourceSelect))
      else $error("zero range left loop running");
   a_manual_quiet:
   assert property (!autoBandwidth [*3] |-> !loopInterrupt) else $error("interrupt in manual mode");
   a_flag_manual:
   assert property (rdDone && avs_address == CTRL_IDX && !autoBandwidth |-> !avs_readdata[CTRL_FLAG_BIT])
      else $error("flag visible in manual mode");
   a_high_nibble:
   assert property (rdDone && (avs_address == MULH_IDX || avs_address == RDS_IDX)
      |-> avs_readdata[7:4] == 4'h0) else $error("unused bits read nonzero");
   a_one_wait:
   assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait cycle count wrong");
   // Main scenarios that the bench must reach.
   c_irq: cover property (loopInterrupt);
   c_stop_vco: cover property (stopMode && baseClockSourceSelect);
   c_flag_read: cover property (rdDone && avs_address == CTRL_IDX && avs_readdata[CTRL_FLAG_BIT]);
endmodule // pll_ctrl_checker
bind pll_ctrl pll_ctrl_checker chk_u (.*);
`default_nettype wire

/* pll_loop_model.sv */
// Behavioural model of the analog loop that reports lock and tracking state.
// Assumes the bench steers lock through lockReq; an idle loop never reports lock.
`timescale 1ns/1ps
`default_nettype none
module pll_loop_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic loopEnable,
   input wire logic lockReq,
   output logic lockDetect,
   output logic loopTracking
);
   logic [2:0] lockLag_r;
   // Lock settles a few cycles late, since a real loop never locks at once.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lockLag_r <= 3'h0;
         loopTracking <= 1'b0;
      end else begin
         lockLag_r <= {lockLag_r[1:0], lockReq && loopEnable};
         loopTracking <= lockLag_r[2];
      end
   end
   assign lockDetect = lockLag_r[2];
endmodule // pll_loop_model
`default_nettype wire

/* pll_ctrl_test.sv */
// Self-checking bench for the loop programming block.
// Assumes the checker binds itself and the loop model stands on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module pll_ctrl_test
   import pll_ctrl_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, lockReq = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, seed = 32'hFB514208, v;
   logic [3:0] avs_byteenable = 4'hF, referenceDivisionFactor;
   logic [1:0] avs_response, prescaleSelect, vcoPowerRange, rsp;
   logic avs_waitrequest, lockDetect, loopTracking, stopMode = 1'b0, oscillatorRunsInStop = 1'b0;
   logic breakActive = 1'b0, breakClearEnable = 1'b0, loopEnable, oscillatorEnable, trackingForce;
   logic autoBandwidth, baseClockSourceSelect, loopInterrupt;
   logic [11:0] feedbackMultiplier;
   logic [7:0] vcoRangeMultiplier, rd;
   logic [7:0] rstVal [6] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01};
   int error_cnt = 0, num_checks = 0;
   pll_ctrl dut_u (.*);
   pll_loop_model model_u (.*);
   // Free-running system clock.
   always #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] expMul(input logic [7:0] h, input logic [7:0] l);
      return ({h[3:0], l} == 12'h000) ? 12'h001 : {h[3:0], l};
   endfunction
   function automatic logic [3:0] expDiv(input logic [7:0] d);
      return (d[3:0] == 4'h0) ? 4'h1 : d[3:0];
   endfunction
   // One bus cycle; the request holds until the rising edge that sees waitrequest low.
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(rd, e)
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The whole sequence needs about five hundred cycles; ten times that means a hang.
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      idle(6);
      foreach (rstVal[i]) rdc(ADDR_W'(i), rstVal[i]);
      bus(1'b0, 3'h6, 8'h00);
      `CHK(rsp, 2'b11)
      $display("test reset done");
      bus(1'b1, CTRL_IDX, 8'h00);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 32'h0 : seed;
         bus(1'b1, MULH_IDX, v[15:8]);
         bus(1'b1, MULL_IDX, v[7:0]);
         bus(1'b1, VRS_IDX, v[23:16]);
         bus(1'b1, RDS_IDX, v[31:24]);
         bus(1'b1, CTRL_IDX, {4'h0, v[3:0]});
         `CHK({prescaleSelect, vcoPowerRange}, v[3:0])
         rdc(MULH_IDX, {4'h0, v[11:8]});
         rdc(RDS_IDX, {4'h0, v[27:24]});
         `CHK(feedbackMultiplier, expMul(v[15:8], v[7:0]))
         `CHK(referenceDivisionFactor, expDiv(v[31:24]))
         `CHK(vcoRangeMultiplier, v[23:16])
      end
      bus(1'b1, VRS_IDX, 8'h40);
      bus(1'b1, CTRL_IDX, 8'h20);
      bus(1'b1, MULL_IDX, ~v[7:0]);
      bus(1'b1, VRS_IDX, 8'h11);
      bus(1'b1, RDS_IDX, ~v[31:24]);
      rdc(MULL_IDX, v[7:0]);
      rdc(VRS_IDX, 8'h40);
      rdc(RDS_IDX, {4'h0, v[27:24]});
      $display("test programming done");
      bus(1'b1, CTRL_IDX, 8'h30);
      rdc(CTRL_IDX, 8'h30);
      `CHK({lockDetect, baseClockSourceSelect}, 2'b01)
      stopMode <= 1'b1;
      idle(4);
      `CHK({oscillatorEnable, loopEnable, baseClockSourceSelect, loopInterrupt}, 4'h0)
      stopMode <= 1'b0;
      idle(4);
      bus(1'b0, CTRL_IDX, 8'h00);
      `CHK({rd[CTRL_BCS_BIT], oscillatorEnable, baseClockSourceSelect}, 3'b010)
      oscillatorRunsInStop <= 1'b1;
      stopMode <= 1'b1;
      idle(4);
      `CHK({oscillatorEnable, loopEnable}, 2'b10)
      stopMode <= 1'b0;
      bus(1'b1, CTRL_IDX, 8'h00);
      bus(1'b1, VRS_IDX, 8'h00);
      bus(1'b1, CTRL_IDX, 8'h20);
      bus(1'b1, CTRL_IDX, 8'h30);
      `CHK({loopEnable, baseClockSourceSelect}, 2'b00)
      bus(1'b1, CTRL_IDX, 8'h00);
      bus(1'b1, VRS_IDX, 8'h40);
      $display("test stop and range done");
      bus(1'b1, CTRL_IDX, 8'h20);
      bus(1'b1, BW_IDX, 8'h20);
      `CHK(trackingForce, 1'b1)
      rdc(BW_IDX, 8'h20);
      bus(1'b1, BW_IDX, 8'hA0);
      bus(1'b1, BW_IDX, 8'h80);
      `CHK({autoBandwidth, trackingForce}, 2'b11)
      rdc(BW_IDX, 8'h80);
      lockReq <= 1'b1;
      idle(8);
      rdc(BW_IDX, 8'hE0);
      `CHK(loopInterrupt, 1'b0)
      rdc(CTRL_IDX, 8'h60);
      rdc(CTRL_IDX, 8'h20);
      bus(1'b1, CTRL_IDX, 8'hA0);
      lockReq <= 1'b0;
      idle(8);
      `CHK(loopInterrupt, 1'b1)
      breakActive <= 1'b1;
      rdc(CTRL_IDX, 8'hE0);
      rdc(CTRL_IDX, 8'hE0);
      breakClearEnable <= 1'b1;
      rdc(CTRL_IDX, 8'hE0);
      rdc(CTRL_IDX, 8'hA0);
      breakActive <= 1'b0;
      idle(2);
      `CHK(loopInterrupt, 1'b0)
      rdc(CTRL_IDX, 8'hA0);
      bus(1'b1, BW_IDX, 8'h00);
      lockReq <= 1'b1;
      idle(8);
      rdc(CTRL_IDX, 8'h20);
      rdc(BW_IDX, 8'h20);
      `CHK(loopInterrupt, 1'b0)
      $display("test lock flag done");
      give_verdict;
   end
endmodule // pll_ctrl_test
`default_nettype wire
